// ### logic/icsc_defines.svh
// register offsets, field positions, reset values and vector codes of the interrupt block
`ifndef ICSC_DEFINES_SVH
`define ICSC_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ICSC_OFS_CORE 8'h00
`define ICSC_OFS_CTL1 8'h04
`define ICSC_OFS_CTL2 8'h08
`define ICSC_OFS_CTL4 8'h0C
`define ICSC_OFS_VSTAT 8'h10
`define ICSC_OFS_SRLVL 8'h14
`define ICSC_OFS_FLAG 8'h18
`define ICSC_OFS_ENAB 8'h1C
`define ICSC_OFS_PRIO 8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define ICSC_EXT_BIT 3
`define ICSC_NEST_BIT 15
`define ICSC_MATH_BIT 4
`define ICSC_ADDR_BIT 3
`define ICSC_STACK_BIT 2
`define ICSC_OSC_BIT 1
`define ICSC_GEN_BIT 15
`define ICSC_TDIS_BIT 14
`define ICSC_SWT_BIT 13
`define ICSC_ALT_BIT 8
`define ICSC_ECC_BIT 1
`define ICSC_SOFTHARD_BIT 0
`define ICSC_PEND_BIT 15
`define ICSC_HOLD_BIT 13
`define ICSC_LVL_LSB 8
`define ICSC_SRLVL_LSB 5
// ----------------------------------------
// reset values
// ----------------------------------------
`define ICSC_RST_GEN 1'b1
`define ICSC_RST_ZERO 1'b0
// ----------------------------------------
// vector codes and levels
// ----------------------------------------
`define ICSC_VEC_OSC 8'h00
`define ICSC_VEC_ADDR 8'h01
`define ICSC_VEC_HARD 8'h02
`define ICSC_VEC_STACK 8'h03
`define ICSC_VEC_MATH 8'h04
`define ICSC_VEC_SOFT 8'h06
`define ICSC_VEC_USER 8'h08
`define ICSC_VEC_RSVD 8'hFF
`define ICSC_TRAP_TOP 4'hF
`define ICSC_USER_MAX 4'h7
`endif

// ### logic/icsc_pkg.sv
// shared types of the interrupt control and status block
package icsc_pkg;
  // wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } icsc_wb_req_s;
  // one-cycle trap events from the core
  typedef struct packed {
    logic ecc_dbe;
    logic math;
    logic addr;
    logic stack;
    logic osc;
  } icsc_trap_s;
  // request towards the core
  typedef struct packed {
    logic req;
    logic [7:0] vec;
    logic [3:0] lvl;
  } icsc_irq_s;
endpackage : icsc_pkg

// ### logic/icsc_top.sv
// interrupt and trap control with status registers on a wishbone slave
// What this block does
// - extension bit reads 1 when cpu level above 7; software only clears it
// - cpu level is extension bit over three status bits; extension blocks user sources
// - nesting disable at control one bit 15 stops nesting; resets to 0
// - math, address, stack, oscillator trap flags at bits 4..1 set on trap
// - global enable at control two bit 15 gates user sources, traps pass; resets 1
// - bit 14 reads 1 while timed disable instruction is active
// - software trap enable at bit 13, writable, resets 0
// - bit 8 selects alternate vector table when configuration allows
// - five polarity bits choose falling edge when 1, rising when 0
// - double-bit ecc trap flag at control four bit 1, clear only
// - software hard trap flag at control four bit 0, clear only
// - status bit 15 shows a request held back by an equal or higher cpu level
// - capture mode bit 13 shows pending vector when 1, last acked when 0
// - bits 11..8 hold the level of the pending or last acked source, as bit 13 selects
// - trap vector codes 0,1,2,3,4; codes 5, 6 and 7 unused
// - external source zero is vector 8, next source 9; 255 never used
// - each user source has a sticky request flag and an enable bit; trap flags are sticky but have no enable bit
// - each user source has a three-bit priority
// - status level bits are read-only while nesting disable is set
`timescale 1ns/1ps
`include "icsc_defines.svh"
module icsc_top #(
  parameter int N_SRC = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // wishbone slave
  input wire icsc_pkg::icsc_wb_req_s wb_req_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  // sources: pins are asynchronous, events and traps are on clock_in
  input wire logic [4:0] ext_irq_pin_in,
  input wire logic [N_SRC-6:0] periph_event_in,
  input wire icsc_pkg::icsc_trap_s trap_event_in,
  // core side
  input wire logic timed_disable_in,
  input wire logic alt_table_allowed_in,
  input wire logic cpu_ack_in,
  input wire logic cpu_level_load_in,
  input wire logic [3:0] cpu_level_in,
  output icsc_pkg::icsc_irq_s irq_out,
  output logic [3:0] cpu_priority_level_out,
  output logic alt_table_active_out
);
  import icsc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic [2:0] sr_level;
    logic priority_extension_bit;
    logic nesting_disable;
    logic math_trap_flag;
    logic address_trap_flag;
    logic stack_trap_flag;
    logic oscillator_fail_trap_flag;
    logic global_irq_enable;
    logic software_trap_enable;
    logic alternate_table_select;
    logic [4:0] external_edge_polarity;
    logic double_bit_ecc_trap_flag;
    logic soft_hard_trap_flag;
    logic vector_capture_mode;
    logic [N_SRC-1:0] request_flag_regs;
    logic [N_SRC-1:0] request_enable_regs;
    logic [3*N_SRC-1:0] source_priority_regs;
    logic [7:0] ack_vec;
    logic [3:0] ack_lvl;
    icsc_irq_s irq;
    logic ack;
    logic [31:0] rdata;
  } icsc_state_s;

  icsc_state_s s_r;
  icsc_state_s s_nxt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte-lane merge of a write into the current image
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // scan traps by code, then user sources by vector; strict compare keeps lower vector on ties
  function automatic icsc_irq_s pick(input logic [4:0] trap_p, input logic [N_SRC-1:0] user_p,
                                     input logic [3*N_SRC-1:0] prio, input logic tdis);
    icsc_irq_s b;
    logic [3:0] l;
    b = '0;
    for (int t = 0; t < 5; t++) begin
      l = `ICSC_TRAP_TOP - 4'(t);
      if (trap_p[t] && (!b.req || l > b.lvl)) begin
        b.req = 1'b1;
        b.lvl = l;
        b.vec = 8'(t);
      end
    end
    for (int i = 0; i < N_SRC; i++) begin
      l = {1'b0, prio[3*i +: 3]};
      // timed disable holds back user levels under 7
      if (user_p[i] && !(tdis && l < `ICSC_USER_MAX) && (!b.req || l > b.lvl)) begin
        b.req = 1'b1;
        b.lvl = l;
        b.vec = `ICSC_VEC_USER + 8'(i);
      end
    end
    return b;
  endfunction : pick

  // ----------------------------------------
  // decode and arbitration
  // ----------------------------------------
  logic [3:0] cpu_level;
  logic [4:0] ext_ev;
  logic [4:0] trap_p;
  logic [N_SRC-1:0] user_p;
  icsc_irq_s pend;
  logic req_now;
  logic held_back;
  logic hit;
  logic wr_go;
  logic ack_take;
  logic [31:0] rd_img;
  logic [31:0] wv;

  assign cpu_level = {s_r.priority_extension_bit, s_r.sr_level};
  // edge select per pin, on synchronised copies only
  assign ext_ev = (s_r.external_edge_polarity & ~s_r.sync2 & s_r.sync3) |
                  (~s_r.external_edge_polarity & s_r.sync2 & ~s_r.sync3);
  // trap index equals its vector code; both hard traps share code 2
  assign trap_p = {s_r.math_trap_flag, s_r.stack_trap_flag,
                   s_r.double_bit_ecc_trap_flag | s_r.soft_hard_trap_flag,
                   s_r.address_trap_flag, s_r.oscillator_fail_trap_flag};
  // global enable and extension bit gate user sources, never traps
  assign user_p = s_r.request_flag_regs & s_r.request_enable_regs &
                  {N_SRC{s_r.global_irq_enable & ~s_r.priority_extension_bit}};
  assign pend = pick(trap_p, user_p, s_r.source_priority_regs, timed_disable_in);
  // raise only above the current cpu level
  assign req_now = pend.req && (pend.lvl > cpu_level);
  // a request that the cpu level holds back
  assign held_back = pend.req && !(pend.lvl > cpu_level);
  assign hit = wb_req_in.cyc && wb_req_in.stb;
  // writes land on the edge where ack is high
  assign wr_go = hit && wb_req_in.we && s_r.ack;
  assign ack_take = cpu_ack_in && s_r.irq.req;
  assign wv = lane_merge(rd_img, wb_req_in.dat, wb_req_in.sel);

  // read image of the addressed register; unmapped reads zero
  always_comb begin
    rd_img = '0;
    case (wb_req_in.adr)
      `ICSC_OFS_CORE: begin
        rd_img[`ICSC_EXT_BIT] = s_r.priority_extension_bit;
      end
      `ICSC_OFS_CTL1: begin
        rd_img[`ICSC_NEST_BIT] = s_r.nesting_disable;
        rd_img[`ICSC_MATH_BIT] = s_r.math_trap_flag;
        rd_img[`ICSC_ADDR_BIT] = s_r.address_trap_flag;
        rd_img[`ICSC_STACK_BIT] = s_r.stack_trap_flag;
        rd_img[`ICSC_OSC_BIT] = s_r.oscillator_fail_trap_flag;
      end
      `ICSC_OFS_CTL2: begin
        rd_img[`ICSC_GEN_BIT] = s_r.global_irq_enable;
        rd_img[`ICSC_TDIS_BIT] = timed_disable_in;
        rd_img[`ICSC_SWT_BIT] = s_r.software_trap_enable;
        rd_img[`ICSC_ALT_BIT] = s_r.alternate_table_select;
        rd_img[4:0] = s_r.external_edge_polarity;
      end
      `ICSC_OFS_CTL4: begin
        rd_img[`ICSC_ECC_BIT] = s_r.double_bit_ecc_trap_flag;
        rd_img[`ICSC_SOFTHARD_BIT] = s_r.soft_hard_trap_flag;
      end
      `ICSC_OFS_VSTAT: begin
        rd_img[`ICSC_PEND_BIT] = held_back;
        rd_img[`ICSC_HOLD_BIT] = s_r.vector_capture_mode;
        // pending or last acknowledged, its level
        if (s_r.vector_capture_mode) begin
          rd_img[`ICSC_LVL_LSB +: 4] = pend.lvl;
          rd_img[7:0] = pend.vec;
        end else begin
          rd_img[`ICSC_LVL_LSB +: 4] = s_r.ack_lvl;
          rd_img[7:0] = s_r.ack_vec;
        end
      end
      `ICSC_OFS_SRLVL: begin
        rd_img[`ICSC_SRLVL_LSB +: 3] = s_r.sr_level;
      end
      `ICSC_OFS_FLAG: begin
        rd_img[N_SRC-1:0] = s_r.request_flag_regs;
      end
      `ICSC_OFS_ENAB: begin
        rd_img[N_SRC-1:0] = s_r.request_enable_regs;
      end
      `ICSC_OFS_PRIO: begin
        rd_img[3*N_SRC-1:0] = s_r.source_priority_regs;
      end
      default: begin
        rd_img = '0;
      end
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    // pin synchroniser, third stage only feeds the edge compare
    s_nxt.sync1 = ext_irq_pin_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    // single-cycle ack, read data captured with it
    s_nxt.ack = hit && !s_r.ack;
    if (hit && !s_r.ack) begin
      s_nxt.rdata = rd_img;
    end
    // software writes first so that hardware sets below win
    if (wr_go) begin
      case (wb_req_in.adr)
        `ICSC_OFS_CORE: begin
          // extension bit can only be cleared
          s_nxt.priority_extension_bit = s_r.priority_extension_bit & wv[`ICSC_EXT_BIT];
        end
        `ICSC_OFS_CTL1: begin
          s_nxt.nesting_disable = wv[`ICSC_NEST_BIT];
          s_nxt.math_trap_flag = wv[`ICSC_MATH_BIT];
          s_nxt.address_trap_flag = wv[`ICSC_ADDR_BIT];
          s_nxt.stack_trap_flag = wv[`ICSC_STACK_BIT];
          s_nxt.oscillator_fail_trap_flag = wv[`ICSC_OSC_BIT];
        end
        `ICSC_OFS_CTL2: begin
          s_nxt.global_irq_enable = wv[`ICSC_GEN_BIT];
          s_nxt.software_trap_enable = wv[`ICSC_SWT_BIT];
          s_nxt.alternate_table_select = wv[`ICSC_ALT_BIT];
          s_nxt.external_edge_polarity = wv[4:0];
        end
        `ICSC_OFS_CTL4: begin
          s_nxt.double_bit_ecc_trap_flag = s_r.double_bit_ecc_trap_flag & wv[`ICSC_ECC_BIT];
          s_nxt.soft_hard_trap_flag = s_r.soft_hard_trap_flag & wv[`ICSC_SOFTHARD_BIT];
        end
        `ICSC_OFS_VSTAT: begin
          s_nxt.vector_capture_mode = wv[`ICSC_HOLD_BIT];
        end
        `ICSC_OFS_SRLVL: begin
          // level bits frozen while nesting is disabled
          if (!s_r.nesting_disable) begin
            s_nxt.sr_level = wv[`ICSC_SRLVL_LSB +: 3];
          end
        end
        `ICSC_OFS_FLAG: begin
          s_nxt.request_flag_regs = wv[N_SRC-1:0];
        end
        `ICSC_OFS_ENAB: begin
          s_nxt.request_enable_regs = wv[N_SRC-1:0];
        end
        `ICSC_OFS_PRIO: begin
          s_nxt.source_priority_regs = wv[3*N_SRC-1:0];
        end
        default: begin
          s_nxt.rdata = s_r.rdata;
        end
      endcase
    end
    s_nxt.math_trap_flag = s_nxt.math_trap_flag | trap_event_in.math;
    s_nxt.address_trap_flag = s_nxt.address_trap_flag | trap_event_in.addr;
    s_nxt.stack_trap_flag = s_nxt.stack_trap_flag | trap_event_in.stack;
    s_nxt.oscillator_fail_trap_flag = s_nxt.oscillator_fail_trap_flag | trap_event_in.osc;
    s_nxt.double_bit_ecc_trap_flag = s_nxt.double_bit_ecc_trap_flag | trap_event_in.ecc_dbe;
    // enabled software trap raises the hard trap flag
    s_nxt.soft_hard_trap_flag = s_nxt.soft_hard_trap_flag | s_r.software_trap_enable;
    // pins then peripheral events set sticky flags
    s_nxt.request_flag_regs = s_nxt.request_flag_regs | {periph_event_in, ext_ev};
    // request is refreshed each cycle and dropped in the ack cycle
    s_nxt.irq.req = req_now && !ack_take;
    s_nxt.irq.vec = pend.vec;
    s_nxt.irq.lvl = pend.lvl;
    if (ack_take) begin
      s_nxt.ack_vec = s_r.irq.vec;
      s_nxt.ack_lvl = s_r.irq.lvl;
      // without nesting a user service runs at level 7
      if (s_r.nesting_disable && !s_r.irq.lvl[3]) begin
        {s_nxt.priority_extension_bit, s_nxt.sr_level} = `ICSC_USER_MAX;
      end else begin
        // a trap lifts the level above 7
        {s_nxt.priority_extension_bit, s_nxt.sr_level} = s_r.irq.lvl;
      end
    end else if (cpu_level_load_in) begin
      // level restored by the core on return
      {s_nxt.priority_extension_bit, s_nxt.sr_level} = cpu_level_in;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
      s_r.global_irq_enable <= `ICSC_RST_GEN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack_out = s_r.ack;
  assign wb_dat_out = s_r.rdata;
  assign irq_out = s_r.irq;
  assign cpu_priority_level_out = cpu_level;
  // alternate table only when configuration permits
  assign alt_table_active_out = s_r.alternate_table_select & alt_table_allowed_in;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence trap_acked_s;
    ack_take && s_r.irq.lvl[3];
  endsequence
  sequence user_acked_nest_off_s;
    ack_take && !s_r.irq.lvl[3] && s_r.nesting_disable && !cpu_level_load_in;
  endsequence

  ext_after_trap_a: assert property (trap_acked_s |=> cpu_priority_level_out[3])
    else $error("extension bit not set after trap ack");
  user_blocked_a: assert property (irq_out.req && irq_out.vec >= `ICSC_VEC_USER
    |-> $past(!cpu_priority_level_out[3] && s_r.global_irq_enable))
    else $error("user request raised while blocked");
  nest_off_level_a: assert property (user_acked_nest_off_s
    |=> cpu_priority_level_out == `ICSC_USER_MAX)
    else $error("nesting disable did not force level 7");
  math_flag_a: assert property (trap_event_in.math |=> s_r.math_trap_flag)
    else $error("math trap flag not set");
  trap_ignores_gen_a: assert property (!s_r.global_irq_enable && s_r.oscillator_fail_trap_flag
    && cpu_priority_level_out < `ICSC_TRAP_TOP && !cpu_ack_in && !cpu_level_load_in && !wr_go
    ##1 !cpu_ack_in |=> irq_out.req)
    else $error("trap blocked by global enable");
  software_trap_enable_set_a: assert property (s_r.software_trap_enable |=> s_r.soft_hard_trap_flag)
    else $error("software trap did not set flag");
  edge_rise_a: assert property (s_r.sync2[0] && !s_r.sync3[0] && !s_r.external_edge_polarity[0]
    |=> s_r.request_flag_regs[0])
    else $error("rising edge missed");
  ecc_sticky_a: assert property (s_r.double_bit_ecc_trap_flag && !wr_go
    |=> s_r.double_bit_ecc_trap_flag)
    else $error("ecc flag lost without a write");
  req_above_a: assert property (irq_out.req
    |-> irq_out.lvl > $past(cpu_priority_level_out))
    else $error("request not above cpu level");
  bus_ack_a: assert property (hit && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single pulse");
endmodule : icsc_top

// ### sim/icsc_core_model.sv
// behavioural cpu core that acknowledges interrupt requests of the block
`timescale 1ns/1ps
module icsc_core_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // request from the block and pacing from the bench
  input wire icsc_pkg::icsc_irq_s irq_in,
  input wire logic [3:0] ack_delay_in,
  // acknowledge and level restore towards the block
  output logic ack_out,
  output logic level_load_out,
  output logic [3:0] level_out
);
  import icsc_pkg::*;
  logic [3:0] wait_r;
  // -----------------------------
  // return path
  // -----------------------------
  // no return from handler here: the bench restores levels through software writes
  assign level_load_out = 1'b0;
  assign level_out = 4'h0;
  // -----------------------------
  // acknowledge
  // -----------------------------
  // ack raised requests only
  // one pulse, then one idle cycle, by which the block has dropped req, so a stale req is never acked twice
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || ack_out || !irq_in.req) begin
      ack_out <= 1'b0;
      wait_r <= 4'h0;
    end else if (wait_r == ack_delay_in) begin
      ack_out <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : icsc_core_model

// ### sim/icsc_top_tb.sv
// self-checking bench for the interrupt control and status block
`timescale 1ns/1ps
`include "icsc_defines.svh"
module icsc_top_tb;
  import icsc_pkg::*;
  logic clock_in;
  logic rst_n_in;
  icsc_wb_req_s wb_req;
  logic wb_ack;
  logic [31:0] wb_dat;
  logic [4:0] pins;
  logic [2:0] periph;
  icsc_trap_s trap;
  logic tdis;
  logic alt_ok;
  logic cpu_ack;
  logic lvl_load;
  logic [3:0] lvl_data;
  icsc_irq_s irq;
  logic [3:0] cpu_lvl;
  logic alt_act;
  logic [3:0] ack_delay;
  int miscompares;
  int checks_done;
  // trap table: osc, stack, addr, math, ecc double
  logic [4:0] trap_ev [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
  logic [7:0] trap_ofs [5] = '{`ICSC_OFS_CTL1, `ICSC_OFS_CTL1, `ICSC_OFS_CTL1,
                               `ICSC_OFS_CTL1, `ICSC_OFS_CTL4};
  logic [7:0] trap_mask [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h02};
  logic [7:0] trap_vec [5] = '{8'h00, 8'h03, 8'h01, 8'h04, 8'h02};
  logic [3:0] trap_lvl [5] = '{4'hF, 4'hC, 4'hE, 4'hB, 4'hD};

  icsc_top #(.N_SRC(8)) icsc_top_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .wb_req_in(wb_req), .wb_ack_out(wb_ack), .wb_dat_out(wb_dat), .ext_irq_pin_in(pins),
    .periph_event_in(periph), .trap_event_in(trap), .timed_disable_in(tdis),
    .alt_table_allowed_in(alt_ok), .cpu_ack_in(cpu_ack), .cpu_level_load_in(lvl_load),
    .cpu_level_in(lvl_data), .irq_out(irq), .cpu_priority_level_out(cpu_lvl),
    .alt_table_active_out(alt_act));
  icsc_core_model icsc_core_model_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .irq_in(irq), .ack_delay_in(ack_delay), .ack_out(cpu_ack), .level_load_out(lvl_load),
    .level_out(lvl_data));

  // -----------------------------
  // clock, watchdog, helpers
  // -----------------------------
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // the whole sequence needs a few hundred cycles; this span of 40000 cycles is ample
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick
  // bounded wait for the request line to reach a level
  task automatic wait_req(input logic want);
    int n;
    n = 0;
    while (irq.req !== want) begin
      @(posedge clock_in);
      n++;
      if (n > 40) begin
        miscompares++;
        conclude();
      end
    end
  endtask : wait_req
  // classic single wishbone cycle, then one idle cycle with cyc and stb low
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] data);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, wd};
    do begin
      @(posedge clock_in);
      n++;
      if (n > 20) begin
        miscompares++;
        conclude();
      end
    end while (wb_ack !== 1'b1);
    data = wb_dat;
    wb_req <= '0;
    @(posedge clock_in);
  endtask : wb_cycle
  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] unused;
    wb_cycle(1'b1, adr, wd, unused);
  endtask : wr
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] data;
    wb_cycle(1'b0, adr, 32'h0, data);
    check(data, exp);
  endtask : rd_chk

  // -----------------------------
  // scenarios
  // -----------------------------
  task automatic test_reset;
    check({irq.req, cpu_lvl, alt_act}, 6'h00); // quiet after reset
    rd_chk(`ICSC_OFS_CORE, 32'h0); // extension clear
    rd_chk(`ICSC_OFS_CTL1, 32'h0); // flags clear
    rd_chk(`ICSC_OFS_CTL2, 32'h8000); // enable set only
    rd_chk(`ICSC_OFS_CTL4, 32'h0); // flags clear
    rd_chk(`ICSC_OFS_VSTAT, 32'h0); // status clear
    wr(`ICSC_OFS_CORE, 32'h8);
    rd_chk(`ICSC_OFS_CORE, 32'h0); // software cannot set
    wr(8'h24, 32'hFFFF);
    rd_chk(8'h24, 32'h0);
    $display("reset test done");
  endtask : test_reset
  // software trap enable raises a hard trap, which the core takes at level 13
  task automatic test_ctl2;
    tdis <= 1'b1;
    alt_ok <= 1'b1;
    wr(`ICSC_OFS_CTL2, 32'hA11F);
    check(alt_act, 1'b1); // alternate table used
    rd_chk(`ICSC_OFS_CTL2, 32'hE11F); // readback
    alt_ok <= 1'b0;
    tdis <= 1'b0;
    tick(1);
    check(alt_act, 1'b0); // not permitted
    rd_chk(`ICSC_OFS_CTL4, 32'h1); // soft hard trap latched
    rd_chk(`ICSC_OFS_CORE, 32'h8); // level above 7
    check(cpu_lvl, 4'hD); // level 13
    wr(`ICSC_OFS_CTL2, 32'h8000);
    wr(`ICSC_OFS_CTL4, 32'h0);
    rd_chk(`ICSC_OFS_CTL4, 32'h0); // cleared by software
    wr(`ICSC_OFS_CORE, 32'h0);
    wr(`ICSC_OFS_SRLVL, 32'h0);
    tick(1);
    check(cpu_lvl, 4'h0); // back to zero
    $display("control two test done");
  endtask : test_ctl2
  // every trap source with global enable off, acked with a different core delay each time
  task automatic test_traps;
    wr(`ICSC_OFS_CTL2, 32'h0);
    for (int i = 0; i < 5; i++) begin
      ack_delay <= 4'(i);
      trap <= icsc_trap_s'(trap_ev[i]);
      tick(1);
      trap <= '0;
      wait_req(1'b1);
      check({irq.vec, irq.lvl}, {trap_vec[i], trap_lvl[i]}); // code and level
      wait_req(1'b0);
      check(cpu_lvl, trap_lvl[i]); // level taken on ack
      rd_chk(trap_ofs[i], {24'h0, trap_mask[i]}); // flag latched
      rd_chk(`ICSC_OFS_CORE, 32'h8); // extension set
      wr(trap_ofs[i], 32'h0);
      wr(`ICSC_OFS_CORE, 32'h0);
      wr(`ICSC_OFS_SRLVL, 32'h0);
    end
    wr(`ICSC_OFS_CTL2, 32'h8000);
    $display("trap test done");
  endtask : test_traps
  // pins 0, 2, 4 on falling edges, pins 1, 3 on rising edges
  task automatic test_pins;
    wr(`ICSC_OFS_CTL2, 32'h8015);
    wr(`ICSC_OFS_FLAG, 32'h0);
    pins <= 5'h1F;
    tick(6);
    rd_chk(`ICSC_OFS_FLAG, 32'h0A); // rising edge pins
    pins <= 5'h00;
    tick(6);
    rd_chk(`ICSC_OFS_FLAG, 32'h1F); // falling edge pins
    wr(`ICSC_OFS_CTL2, 32'h8000);
    wr(`ICSC_OFS_FLAG, 32'h0);
    $display("polarity test done");
  endtask : test_pins
  // pin 0 at priority 3 and peripheral source 5 at priority 5
  task automatic test_user;
    wr(`ICSC_OFS_SRLVL, 32'hE0);
    wr(`ICSC_OFS_PRIO, 32'h28003);
    wr(`ICSC_OFS_ENAB, 32'h21);
    wr(`ICSC_OFS_VSTAT, 32'h2000);
    periph <= 3'h1;
    pins <= 5'h01;
    tick(1);
    periph <= 3'h0;
    tick(6);
    check(irq.req, 1'b0); // level 7 blocks
    rd_chk(`ICSC_OFS_VSTAT, 32'hA50D); // held back
    wr(`ICSC_OFS_SRLVL, 32'h0);
    wait_req(1'b1);
    check({irq.vec, irq.lvl}, {8'h0D, 4'h5}); // higher wins
    wait_req(1'b0);
    check(cpu_lvl, 4'h5); // new level
    wr(`ICSC_OFS_FLAG, 32'h1);
    rd_chk(`ICSC_OFS_VSTAT, 32'hA308); // pin zero is vector 8
    wr(`ICSC_OFS_VSTAT, 32'h0);
    rd_chk(`ICSC_OFS_VSTAT, 32'h850D); // last acked shown
    wr(`ICSC_OFS_CTL2, 32'h0);
    wr(`ICSC_OFS_SRLVL, 32'h0);
    tick(4);
    check(irq.req, 1'b0); // global enable off
    wr(`ICSC_OFS_CTL2, 32'h8000);
    wait_req(1'b1);
    check({irq.vec, irq.lvl}, {8'h08, 4'h3}); // pin zero served
    wait_req(1'b0);
    pins <= 5'h00;
    tick(6);
    wr(`ICSC_OFS_FLAG, 32'h0);
    wr(`ICSC_OFS_ENAB, 32'h0);
    wr(`ICSC_OFS_SRLVL, 32'h0);
    $display("user source test done");
  endtask : test_user
  // with nesting off an ack raises the level to 7 and locks the status bits
  task automatic test_nest;
    wr(`ICSC_OFS_PRIO, 32'h1);
    wr(`ICSC_OFS_ENAB, 32'h1);
    wr(`ICSC_OFS_CTL1, 32'h8000);
    wr(`ICSC_OFS_FLAG, 32'h1);
    wait_req(1'b1);
    wait_req(1'b0);
    check(cpu_lvl, 4'h7); // no nesting
    wr(`ICSC_OFS_FLAG, 32'h0);
    wr(`ICSC_OFS_ENAB, 32'h0);
    wr(`ICSC_OFS_SRLVL, 32'h0);
    rd_chk(`ICSC_OFS_SRLVL, 32'hE0); // level bits locked
    rd_chk(`ICSC_OFS_CTL1, 32'h8000); // control readback
    wr(`ICSC_OFS_CTL1, 32'h0);
    wr(`ICSC_OFS_SRLVL, 32'h0);
    rd_chk(`ICSC_OFS_SRLVL, 32'h0); // writable again
    $display("nesting test done");
  endtask : test_nest

  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    rst_n_in = 1'b0;
    wb_req = '0;
    pins = 5'h00;
    periph = 3'h0;
    trap = '0;
    tdis = 1'b0;
    alt_ok = 1'b0;
    ack_delay = 4'h2;
    miscompares = 0;
    checks_done = 0;
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    tick(2);
    test_reset();
    test_ctl2();
    test_traps();
    test_pins();
    test_user();
    test_nest();
    conclude();
  end
endmodule : icsc_top_tb
